/* File: logic/sirqls_top.sv */
// sirqls_top: trigger selection and level status registers with their serial frame engine
// How it works
// - one select bit per line, one means level
// - all resets clear select and status bits
// - level line asserted in stream sets flag
// - writing one clears flag and re-arms line
// - edge-selected lines never set a flag
// - status bit reads one once level line asserted
// - status at 4Ch and alias E4h, shared
// - start frame four, six or eight clocks
// - poll bit picks continuous or quiet mode
// - recovery drives high or floats per bit
`timescale 1ns/1ps
module sirqls_top
    import sirqls_pkg::*;
#(
    parameter int LINES = NUM_LINES
) (
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    input  wire logic                     ce,
    input  wire logic                     link_reset_in,
    input  wire logic                     global_reset_in,
    input  wire sirqls_req_type           reg_req,
    output logic [15:0]                   reg_rdata_ff,
    output logic                          reg_ack_ff,
    input  wire logic                     serial_interrupt_line_i,
    output logic                          serial_interrupt_line_o,
    output logic                          serial_interrupt_line_oe,
    output logic [LINES-1:0]              line_level_flags_ff
);

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic [1:0] link_rst_sync_ff;   // link reset, two stages
    logic [1:0] glob_rst_sync_ff;   // global reset, two stages
    logic [1:0] line_sync_ff;       // serial interrupt line, two stages
    logic       clear_all;          // any reset source active

    // two flip-flop synchronisers; only the second stage is used
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            link_rst_sync_ff <= 2'h0;
            glob_rst_sync_ff <= 2'h0;
            line_sync_ff     <= 2'h3;
        end else if (ce) begin
            link_rst_sync_ff <= {link_rst_sync_ff[0], link_reset_in};
            glob_rst_sync_ff <= {glob_rst_sync_ff[0], global_reset_in};
            line_sync_ff     <= {line_sync_ff[0], serial_interrupt_line_i};
        end
    end

    // power-on, link and global reset all clear the block
    assign clear_all = !rst_n || link_rst_sync_ff[1] || glob_rst_sync_ff[1];

    // ****************************************************************
    // register decode
    // ****************************************************************
    logic                    hit_mode;     // mode control addressed
    logic                    hit_select;   // trigger select addressed
    logic                    hit_status;   // level status addressed
    logic [MODE_BITS-1:0]    mode_ff;      // width, poll, drive bits
    logic [LINES-1:0]        select_ff;    // trigger select per line
    logic [LINES-1:0]        nxt_status;   // next level status
    logic [LINES-1:0]        status_ff;    // level status per line
    logic [LINES-1:0]        set_vec;      // lines flagged this cycle
    logic [LINES-1:0]        clr_vec;      // lines re-armed this cycle

    // both views of each register hit the same storage
    always_comb begin
        hit_mode   = (reg_req.space == SPACE_MEM) ? (reg_req.addr == MEM_MODE_OFF)
                                                  : (reg_req.addr == CFG_MODE_OFF);
        hit_select = (reg_req.space == SPACE_MEM) ? (reg_req.addr == MEM_SELECT_OFF)
                                                  : (reg_req.addr == CFG_SELECT_OFF);
        hit_status = (reg_req.space == SPACE_MEM) ? (reg_req.addr == MEM_STATUS_OFF)
                                                  : (reg_req.addr == CFG_STATUS_OFF);
    end

    // ****************************************************************
    // mode control and trigger select
    // ****************************************************************
    // plain read/write storage, cleared by every reset source
    always_ff @(posedge clk) begin
        if (clear_all) begin
            mode_ff   <= MODE_RESET;
            select_ff <= SELECT_RESET;
        end else if (ce && reg_req.wr) begin
            if (hit_mode) begin
                mode_ff <= reg_req.wdata[MODE_BITS-1:0];
            end
            if (hit_select) begin
                select_ff <= reg_req.wdata[LINES-1:0];
            end
        end
    end

    // ****************************************************************
    // frame engine
    // ****************************************************************
    logic                       slot_strobe;    // one slot sampled
    logic [$clog2(LINES)-1:0]   slot_idx;       // which slot
    logic                       slot_asserted;  // slot showed the line asserted

    sirqls_frame #(
        .LINES (LINES)
    ) u_frame (
        .clk              (clk),
        .rst_n            (rst_n),
        .ce               (ce),
        .clear            (clear_all),
        .width_code       (mode_ff[MODE_WIDTH_LSB +: 2]),
        .quiet            (mode_ff[MODE_POLL_BIT]),
        .tristate_rec     (mode_ff[MODE_DRIVE_BIT]),
        .line_in          (line_sync_ff[1]),
        .line_o_ff        (serial_interrupt_line_o),
        .line_oe_ff       (serial_interrupt_line_oe),
        .slot_strobe_ff   (slot_strobe),
        .slot_idx_ff      (slot_idx),
        .slot_asserted_ff (slot_asserted)
    );

    // ****************************************************************
    // level status flags
    // ****************************************************************
    // per-line set and re-arm terms
    genvar g;
    generate
        for (g = 0; g < LINES; g++) begin : g_line
            // only level-selected lines ever flag
            assign set_vec[g] = slot_strobe && slot_asserted && select_ff[g]
                                && (slot_idx == ($clog2(LINES))'(g));
            // write of one to an asserted bit re-arms it
            assign clr_vec[g] = reg_req.wr && hit_status && reg_req.wdata[g];
        end
    endgenerate

    // set wins over a re-arm in the same cycle; flags hold otherwise
    always_comb begin
        nxt_status = (status_ff & ~clr_vec) | set_vec;
    end

    // status storage and its copy on the output pins
    always_ff @(posedge clk) begin
        if (clear_all) begin
            status_ff           <= STATUS_RESET;
            line_level_flags_ff <= STATUS_RESET;
        end else if (ce) begin
            status_ff           <= nxt_status;
            line_level_flags_ff <= nxt_status;
        end
    end

    // ****************************************************************
    // read port
    // ****************************************************************
    // answers one cycle after each strobe, unmapped offsets read zero
    always_ff @(posedge clk) begin
        if (clear_all) begin
            reg_rdata_ff <= 16'h0000;
            reg_ack_ff   <= 1'b0;
        end else if (ce) begin
            reg_ack_ff <= reg_req.rd || reg_req.wr;
            if (reg_req.rd) begin
                if (hit_status) begin
                    reg_rdata_ff <= status_ff;
                end else if (hit_select) begin
                    reg_rdata_ff <= select_ff;
                end else if (hit_mode) begin
                    reg_rdata_ff <= {12'h000, mode_ff};
                end else begin
                    reg_rdata_ff <= 16'h0000;
                end
            end
        end
    end

endmodule : sirqls_top

/* File: include/sirqls_pkg.sv */
// sirqls_pkg: shared constants, types and register map of the serial interrupt level status block
package sirqls_pkg;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic       SPACE_MEM        = 1'b0;   // device-control memory window
    localparam logic       SPACE_CFG        = 1'b1;   // classic configuration space
    localparam logic [7:0] MEM_MODE_OFF     = 8'h48;  // mode control, memory window
    localparam logic [7:0] CFG_MODE_OFF     = 8'he0;  // mode control, configuration alias
    localparam logic [7:0] MEM_SELECT_OFF   = 8'h4a;  // trigger select, memory window
    localparam logic [7:0] CFG_SELECT_OFF   = 8'he2;  // trigger select, configuration alias
    localparam logic [7:0] MEM_STATUS_OFF   = 8'h4c;  // level status, memory window
    localparam logic [7:0] CFG_STATUS_OFF   = 8'he4;  // level status, configuration alias

    // ****************************************************************
    // field layout and reset values
    // ****************************************************************
    localparam int          MODE_DRIVE_BIT  = 0;      // recovery drive select
    localparam int          MODE_POLL_BIT   = 1;      // continuous or quiet select
    localparam int          MODE_WIDTH_LSB  = 2;      // start width field, bits 3:2
    localparam int          MODE_BITS       = 4;      // implemented mode bits
    localparam logic [3:0]  MODE_RESET      = 4'h0;   // mode control after reset
    localparam logic [15:0] SELECT_RESET    = 16'h0000; // all lines edge-triggered
    localparam logic [15:0] STATUS_RESET    = 16'h0000; // no flags

    // ****************************************************************
    // start frame widths and frame timing, in serial clocks
    // ****************************************************************
    localparam logic [1:0] WIDTH_CODE_4     = 2'h0;   // four clocks
    localparam logic [1:0] WIDTH_CODE_6     = 2'h1;   // six clocks
    localparam logic [1:0] WIDTH_CODE_8     = 2'h2;   // eight clocks
    localparam logic [3:0] START_CLKS_4     = 4'h4;
    localparam logic [3:0] START_CLKS_6     = 4'h6;
    localparam logic [3:0] START_CLKS_8     = 4'h8;
    localparam logic [3:0] STOP_CLKS_QUIET  = 4'h2;   // stop frame in quiet mode
    localparam logic [3:0] STOP_CLKS_CONT   = 4'h3;   // stop frame in continuous mode
    localparam int         NUM_LINES        = 16;     // interrupt slots per frame

    // ****************************************************************
    // register request carrier
    // ****************************************************************
    typedef struct packed {
        logic        wr;      // write strobe, one cycle
        logic        rd;      // read strobe, one cycle
        logic        space;   // memory window or configuration alias
        logic [7:0]  addr;    // byte offset within the chosen space
        logic [15:0] wdata;   // write data
    } sirqls_req_type;

endpackage : sirqls_pkg

/* File: logic/sirqls_frame.sv */
// sirqls_frame: serial interrupt frame engine, start frame, slot sampling, stop frame
`timescale 1ns/1ps
module sirqls_frame
    import sirqls_pkg::*;
#(
    parameter int LINES = NUM_LINES
) (
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    input  wire logic                     ce,
    input  wire logic                     clear,
    input  wire logic [1:0]               width_code,
    input  wire logic                     quiet,
    input  wire logic                     tristate_rec,
    input  wire logic                     line_in,
    output logic                          line_o_ff,
    output logic                          line_oe_ff,
    output logic                          slot_strobe_ff,
    output logic [$clog2(LINES)-1:0]      slot_idx_ff,
    output logic                          slot_asserted_ff
);

    // ****************************************************************
    // state and counters
    // ****************************************************************
    typedef enum {st_idle, st_start, st_start_rec, st_start_turn,
                  st_sample, st_slot_rec, st_slot_turn,
                  st_stop, st_stop_rec, st_stop_turn} sirqls_state_type;

    sirqls_state_type                st_ff;      // frame phase
    logic [3:0]                      cnt_ff;     // clocks left in a driven phase
    logic [$clog2(LINES)-1:0]        slot_ff;    // current slot
    logic [3:0]                      start_clks; // decoded start width

    // decode start width, reserved code falls back to four clocks
    always_comb begin
        unique case (width_code)
            WIDTH_CODE_6: start_clks = START_CLKS_6;
            WIDTH_CODE_8: start_clks = START_CLKS_8;
            default:      start_clks = START_CLKS_4;
        endcase
    end

    // ****************************************************************
    // frame sequencer
    // ****************************************************************
    // walks start, sixteen slots of three clocks, stop, recovery
    always_ff @(posedge clk) begin
        if (clear) begin
            st_ff            <= st_idle;
            cnt_ff           <= 4'h0;
            slot_ff          <= '0;
            line_o_ff        <= 1'b1;
            line_oe_ff       <= 1'b0;
            slot_strobe_ff   <= 1'b0;
            slot_idx_ff      <= '0;
            slot_asserted_ff <= 1'b0;
        end else if (ce) begin
            slot_strobe_ff <= 1'b0;
            unique case (st_ff)
                st_idle: begin
                    // continuous runs frames back to back, quiet waits for a request
                    if (!quiet || !line_in) begin
                        st_ff      <= st_start;
                        cnt_ff     <= start_clks - 4'h1;
                        line_o_ff  <= 1'b0;
                        line_oe_ff <= 1'b1;
                    end
                end
                st_start: begin
                    if (cnt_ff == 4'h0) begin
                        st_ff      <= st_start_rec;
                        line_o_ff  <= 1'b1;
                        line_oe_ff <= !tristate_rec;
                    end else begin
                        cnt_ff <= cnt_ff - 4'h1;
                    end
                end
                st_start_rec: begin
                    st_ff      <= st_start_turn;
                    line_oe_ff <= 1'b0;
                end
                st_start_turn: begin
                    st_ff   <= st_sample;
                    slot_ff <= '0;
                end
                st_sample: begin
                    st_ff <= st_slot_rec;
                end
                st_slot_rec: begin
                    st_ff <= st_slot_turn;
                end
                st_slot_turn: begin
                    // the synchroniser lags two clocks, so the sample phase is seen now
                    slot_strobe_ff   <= 1'b1;
                    slot_idx_ff      <= slot_ff;
                    slot_asserted_ff <= !line_in;  // low in the sample phase means asserted
                    if (slot_ff == LINES[$clog2(LINES)-1:0] - 1'b1) begin
                        st_ff      <= st_stop;
                        cnt_ff     <= (quiet ? STOP_CLKS_QUIET : STOP_CLKS_CONT) - 4'h1;
                        line_o_ff  <= 1'b0;
                        line_oe_ff <= 1'b1;
                    end else begin
                        st_ff   <= st_sample;
                        slot_ff <= slot_ff + 1'b1;
                    end
                end
                st_stop: begin
                    if (cnt_ff == 4'h0) begin
                        st_ff      <= st_stop_rec;
                        line_o_ff  <= 1'b1;
                        line_oe_ff <= !tristate_rec;
                    end else begin
                        cnt_ff <= cnt_ff - 4'h1;
                    end
                end
                st_stop_rec: begin
                    st_ff      <= st_stop_turn;
                    line_oe_ff <= 1'b0;
                end
                st_stop_turn: begin
                    st_ff <= st_idle;
                end
            endcase
        end
    end

endmodule : sirqls_frame

/* File: sim/sirqls_assertions.sv */
// sirqls_assertions: port-level checker for the level status block
`timescale 1ns/1ps
module sirqls_checker
    import sirqls_pkg::*;
#(
    parameter int LINES = NUM_LINES
) (
    input wire logic             clk,
    input wire logic             rst_n,
    input wire logic             ce,
    input wire logic             link_reset_in,
    input wire logic             global_reset_in,
    input wire sirqls_req_type   reg_req,
    input wire logic [15:0]      reg_rdata_ff,
    input wire logic             reg_ack_ff,
    input wire logic             serial_interrupt_line_o,
    input wire logic             serial_interrupt_line_oe,
    input wire logic [LINES-1:0] line_level_flags_ff
);
    // ****************************************************************
    // decode and shadow state
    // ****************************************************************
    logic             sel_hit;      // request targets trigger select
    logic             stat_hit;     // request targets level status
    logic             mode_hit;     // request targets mode control
    logic             any_rst;      // any reset source active
    logic             low_now;      // engine drives the line low
    logic [LINES-1:0] sel_ff;       // shadow of trigger select
    logic             drive_ff;     // shadow of recovery drive bit
    logic [LINES-1:0] w1c_ff [4];   // recent clear masks
    logic [2:0]       rst_age_ff;   // cycles since a reset, saturating
    assign sel_hit  = reg_req.addr == (reg_req.space ? CFG_SELECT_OFF : MEM_SELECT_OFF);
    assign stat_hit = reg_req.addr == (reg_req.space ? CFG_STATUS_OFF : MEM_STATUS_OFF);
    assign mode_hit = reg_req.addr == (reg_req.space ? CFG_MODE_OFF : MEM_MODE_OFF);
    assign any_rst  = link_reset_in || global_reset_in || !rst_n;
    assign low_now  = serial_interrupt_line_oe && !serial_interrupt_line_o;
    // follow writes to select and mode, cleared by any reset
    always_ff @(posedge clk) begin
        if (any_rst) begin
            sel_ff   <= '0;
            drive_ff <= 1'b0;
        end else if (ce && reg_req.wr && sel_hit) begin
            sel_ff <= reg_req.wdata[LINES-1:0];
        end else if (ce && reg_req.wr && mode_hit) begin
            drive_ff <= reg_req.wdata[MODE_DRIVE_BIT];
        end
    end
    // keep the last four status clear masks
    always_ff @(posedge clk) begin
        w1c_ff[0] <= (reg_req.wr && stat_hit) ? reg_req.wdata[LINES-1:0] : '0;
        for (int k = 1; k < 4; k++)
            w1c_ff[k] <= w1c_ff[k-1];
    end
    // age since the last reset, so reset fallout is excused
    always_ff @(posedge clk) begin
        rst_age_ff <= any_rst ? 3'h0 : (rst_age_ff == 3'h7 ? 3'h7 : rst_age_ff + 3'h1);
    end
    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_ack_follows_req: assert property (ce && (reg_req.rd || reg_req.wr) |=> reg_ack_ff)
        else $error("register access not acknowledged");
    a_ack_has_cause: assert property (reg_ack_ff |-> $past(ce && (reg_req.rd || reg_req.wr)))
        else $error("acknowledge without request");
    a_unmapped_zero: assert property (ce && reg_req.rd && !(sel_hit || stat_hit || mode_hit)
        |=> reg_rdata_ff == 16'h0000) else $error("unmapped read not zero");
    a_mode_upper_zero: assert property (ce && reg_req.rd && mode_hit |=> reg_rdata_ff[15:MODE_BITS] == '0)
        else $error("unused mode bits read nonzero");
    a_link_clears: assert property ((ce && link_reset_in)[*3] |-> ##2 line_level_flags_ff == '0)
        else $error("link reset left flags set");
    a_global_clears: assert property ((ce && global_reset_in)[*3] |-> ##2 line_level_flags_ff == '0)
        else $error("global reset left flags set");
    a_edge_never_flags: assert property ((line_level_flags_ff & ~$past(line_level_flags_ff)
        & ~(sel_ff | $past(sel_ff, 4))) == '0) else $error("edge line raised a flag");
    a_flag_holds: assert property (rst_age_ff == 3'h7 |-> ($past(line_level_flags_ff) & ~line_level_flags_ff
        & ~(w1c_ff[0] | w1c_ff[1] | w1c_ff[2] | w1c_ff[3])) == '0) else $error("flag dropped uncleared");
    a_recovery_level: assert property ($past(low_now) && !low_now && rst_age_ff == 3'h7
        && drive_ff == $past(drive_ff, 8) |-> serial_interrupt_line_o && serial_interrupt_line_oe == !drive_ff)
        else $error("recovery cycle drive wrong");
endmodule : sirqls_checker

bind sirqls_top sirqls_checker #(.LINES(LINES)) chk_u (.clk, .rst_n, .ce, .link_reset_in, .global_reset_in,
    .reg_req, .reg_rdata_ff, .reg_ack_ff, .serial_interrupt_line_o, .serial_interrupt_line_oe,
    .line_level_flags_ff);

/* File: sim/sirqls_peripheral.sv */
// sirqls_peripheral: peripherals answering in their slots of the serial interrupt stream
`timescale 1ns/1ps
module sirqls_peripheral (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        host_o,
    input  wire logic        host_oe,
    input  wire logic [15:0] line_mask,
    output logic             line_wire
);
    logic       host_low;  // host drives the line low
    logic [3:0] run_ff;    // length of the host low run
    logic [5:0] pos_ff;    // place after start frame, 0 when idle
    int         slot;      // slot of this cycle
    int         phase;     // 0 sample, 1 recovery, 2 turnaround
    logic       drv;       // peripheral drives the line
    assign host_low = host_oe && !host_o;
    assign slot     = (int'(pos_ff) - 2) / 3;
    assign phase    = (int'(pos_ff) - 2) % 3;
    // measure host low runs; four or more is a start frame
    always_ff @(posedge clk) begin
        run_ff <= host_low ? run_ff + 4'h1 : 4'h0;
    end
    // walk the sixteen three-cycle slots after the start frame
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pos_ff <= 6'h00;
        end else if (!host_low && run_ff >= 4'h4) begin
            pos_ff <= 6'h01;
        end else if (pos_ff != 6'h00 && pos_ff < 6'h31) begin
            pos_ff <= pos_ff + 6'h01;
        end else begin
            pos_ff <= 6'h00;
        end
    end
    // asserted line: low in sample, high in recovery, released after
    assign drv       = pos_ff >= 6'h02 && phase != 2 && line_mask[slot[3:0]];
    // released line is held high by the pull-up
    assign line_wire = host_oe ? host_o : (drv ? (phase == 1) : 1'b1);
endmodule : sirqls_peripheral

/* File: sim/serial_irq_level_status_bench.sv */
// serial_irq_level_status_bench: register, reset and slot stimulus for the level status block
`timescale 1ns/1ps
module serial_irq_level_status_bench import sirqls_pkg::*;;
    logic           clk, rst_n, ce, link_rst, glob_rst, ack, lo, loe, wire_lvl;
    sirqls_req_type req;
    logic [15:0]    rdata, flags, mask, sel, w, exp_st, got;
    logic [8:0]     offs [6] = '{9'h048, 9'h04a, 9'h04c, 9'h1e0, 9'h1e2, 9'h1e4};
    int             failures, checks_done, seed, mx;
    sirqls_top #(.LINES(16)) dut_u (.clk, .rst_n, .ce, .link_reset_in(link_rst), .global_reset_in(glob_rst),
        .reg_req(req), .reg_rdata_ff(rdata), .reg_ack_ff(ack), .serial_interrupt_line_i(wire_lvl),
        .serial_interrupt_line_o(lo), .serial_interrupt_line_oe(loe), .line_level_flags_ff(flags));
    sirqls_peripheral peer_u (.clk, .rst_n, .host_o(lo), .host_oe(loe), .line_mask(mask), .line_wire(wire_lvl));
    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // one register cycle: one-cycle strobe, bounded wait for acknowledge
    task automatic access(input logic wr, input logic sp, input logic [7:0] a, input logic [15:0] wd);
        int n;
        @(negedge clk);
        req = '{wr, !wr, sp, a, wd};
        @(negedge clk);
        req = '0;
        n = 0;
        while (ack !== 1'b1 && n < 4) begin
            @(negedge clk);
            n++;
        end
        if (ack !== 1'b1) failures++;
        got = rdata;
    endtask : access
    // longest run of the line driven low over a full frame span
    task automatic longest_low(output int m);
        int r;
        m = 0;
        r = 0;
        repeat (90) begin
            @(negedge clk);
            r = (loe && !lo) ? r + 1 : 0;
            if (r > m) m = r;
        end
    endtask : longest_low
    // pulse the link or the global reset pin
    task automatic pin_reset(input logic use_link);
        @(negedge clk);
        link_rst = use_link;
        glob_rst = !use_link;
        repeat (4) @(negedge clk);
        link_rst = 1'b0;
        glob_rst = 1'b0;
        repeat (4) @(negedge clk);
    endtask : pin_reset
    // start frame length expected for a width code
    function automatic logic [15:0] exp_width(input logic [1:0] code);
        return code == WIDTH_CODE_6 ? 16'(START_CLKS_6) : code == WIDTH_CODE_8 ? 16'(START_CLKS_8) : 16'(START_CLKS_4);
    endfunction : exp_width
    // verdict and end of run
    task automatic complete_run;
        if (failures == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : complete_run
    // hang guard
    initial begin
        repeat (30000) @(posedge clk);
        failures++;
        complete_run();
    end
    // main sequence
    initial begin
        seed = 32'h8495fcef;
        failures = 0;
        checks_done = 0;
        {rst_n, link_rst, glob_rst, req, mask, exp_st} = '0;
        ce = 1'b1;
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        foreach (offs[i]) begin
            access(1'b0, offs[i][8], offs[i][7:0], 16'h0000);
            check(got, 16'h0000);
        end
        access(1'b1, SPACE_MEM, 8'h4e, 16'hffff);
        access(1'b0, SPACE_MEM, 8'h4e, 16'h0000);
        check(got, 16'h0000);
        // every width code, random drive bit
        for (int c = 0; c < 4; c++) begin
            access(1'b1, SPACE_CFG, CFG_MODE_OFF, 16'(c << MODE_WIDTH_LSB) | 16'($random(seed) & 1));
            repeat (70) @(negedge clk);
            longest_low(mx);
            check(16'(mx), exp_width(2'(c)));
        end
        // quiet mode with a silent line starts no frame
        access(1'b1, SPACE_MEM, MEM_MODE_OFF, 16'h0002);
        access(1'b0, SPACE_CFG, CFG_MODE_OFF, 16'h0000);
        check(got, 16'h0002);
        repeat (70) @(negedge clk);
        longest_low(mx);
        check(16'(mx), 16'h0000);
        access(1'b1, SPACE_MEM, MEM_MODE_OFF, 16'h0000);
        // random selects and slot activity, then partial clears
        repeat (4) begin
            mask = 16'h0000;
            sel = 16'($random(seed));
            access(1'b1, SPACE_MEM, MEM_SELECT_OFF, sel);
            access(1'b0, SPACE_CFG, CFG_SELECT_OFF, 16'h0000);
            check(got, sel);
            mask = 16'($random(seed));
            repeat (150) @(negedge clk);
            exp_st = exp_st | (sel & mask);
            access(1'b0, SPACE_MEM, MEM_STATUS_OFF, 16'h0000);
            check(got, exp_st);
            mask = 16'h0000;
            repeat (70) @(negedge clk);
            check(flags, exp_st);
            // clock enable low freezes the flags against slot activity
            ce = 1'b0;
            mask = 16'hffff;
            repeat (70) @(negedge clk);
            check(flags, exp_st);
            mask = 16'h0000;
            ce = 1'b1;
            w = 16'($random(seed));
            access(1'b1, SPACE_CFG, CFG_STATUS_OFF, w);
            exp_st = exp_st & ~w;
            access(1'b0, SPACE_CFG, CFG_STATUS_OFF, 16'h0000);
            check(got, exp_st);
        end
        // link then global reset pin clear flags and selects
        for (int k = 0; k < 2; k++) begin
            mask = 16'hffff;
            access(1'b1, SPACE_MEM, MEM_SELECT_OFF, 16'hffff);
            repeat (150) @(negedge clk);
            check(flags, 16'hffff);
            pin_reset(k == 0);
            access(1'b0, SPACE_MEM, MEM_STATUS_OFF, 16'h0000);
            check(got, 16'h0000);
            access(1'b0, SPACE_CFG, CFG_SELECT_OFF, 16'h0000);
            check(got, 16'h0000);
        end
        complete_run();
    end
endmodule : serial_irq_level_status_bench
